/* verification/hsl_mem_model.sv */
`timescale 1ns/1ps
module hsl_mem_model (
    // Clock, reset, pacing and endianness
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic big_i,
    // Memory data bus
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_ack_o,
    // Observation
    output logic [31:0] last_addr_o,
    output logic [31:0] last_wdata_o,
    output logic [7:0] acks_o
);
    // ****************************************
    // Word store and acknowledge
    // ****************************************
    logic [31:0] mem [16];
    logic [1:0] wait_q;
    logic [31:0] drv_q;
    logic ack_q;
    logic [3:0] idx;
    assign idx = mem_addr_i[5:2];
    assign mem_ack_o = ack_q;
    // Idle bus keeps changing so stale data cannot pass for a load
    assign mem_rdata_o = ack_q ? mem[idx] : ~drv_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
            wait_q <= 2'h0;
            drv_q <= 32'h5a5a_5a5a;
        end else begin
            drv_q <= mem_rdata_o;
            if (mem_req_i && !ack_q && (!slow_i || wait_q == 2'h3)) begin
                ack_q <= 1'b1;
                wait_q <= 2'h0;
            end else begin
                ack_q <= 1'b0;
                wait_q <= (mem_req_i && !ack_q) ? wait_q + 2'h1 : 2'h0;
            end
        end
    end
    // Only the addressed half changes on a halfword store
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acks_o <= 8'h00;
        end else if (mem_req_i && ack_q) begin
            acks_o <= acks_o + 8'h01;
            last_addr_o <= mem_addr_i;
            last_wdata_o <= mem_wdata_i;
            if (mem_we_i && (mem_addr_i[1] ^ big_i)) begin
                mem[idx][31:16] <= mem_wdata_i[31:16];
            end else if (mem_we_i) begin
                mem[idx][15:0] <= mem_wdata_i[15:0];
            end
        end
    end
endmodule // hsl_mem_model

/* verification/tb_halfword_signed_load_store_unit.sv */
`timescale 1ns/1ps
module tb_halfword_signed_load_store_unit
    import hsl_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic ref_clk_i = 0, nrst_i = 0, ce_i = 1, sw_wr_i = 0, sw_rd_i = 0, instr_valid_i = 0, big = 0, slow = 0;
    logic [3:0] sw_addr_i = 0, flags_i = 0;
    logic [31:0] sw_wdata_i = 0, instr_i = 0;
    logic [31:0] sw_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, last_addr, last_wdata;
    logic instr_ready_o, done_o, skipped_o, mem_req_o, mem_we_o, mem_ack_i, aerr, half;
    logic [7:0] acks;
    int miscompares = 0, checks = 0, aerrs = 0;
    // Flags per condition code in encoding order; even codes pass, odd codes fail
    localparam logic [3:0] FL [16] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h8, 4'h8, 4'h1, 4'h1,
                                       4'h2, 4'h2, 4'h9, 4'h9, 4'h0, 4'h0, 4'h0, 4'hf};
    localparam logic [15:0] EX = 16'h5555;

    hsl_unit #(.DW(32), .AW(4)) hsl_unit_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .flags_i(flags_i),
        .instr_ready_o(instr_ready_o), .done_o(done_o), .skipped_o(skipped_o), .align_err_o(aerr),
        .endian_select_input_i(big), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_half_o(half),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
    hsl_mem_model hsl_mem_model_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .slow_i(slow), .big_i(big),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .last_addr_o(last_addr),
        .last_wdata_o(last_wdata), .acks_o(acks));

    always #10 ref_clk_i = ~ref_clk_i;

    // Alignment flag pulses for one cycle only, so count them
    always @(posedge ref_clk_i) begin
        if (aerr === 1'b1) aerrs++;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] enc(logic [3:0] c, logic [4:0] puiwl, logic [3:0] rn, logic [3:0] rd,
                                        logic [1:0] sh, logic [7:0] off);
        return {c, 3'h0, puiwl, rn, rd, off[7:4], 1'b1, sh, 1'b1, off[3:0]};
    endfunction

    // Reference lane pick and extension
    function automatic logic [31:0] pick(logic [31:0] w, logic [1:0] a, logic b, logic s, logic h);
        logic [31:0] v;
        if (h) begin
            v = (a[1] ^ b) ? w >> 16 : w;
            return s ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
        end
        v = b ? w >> (8 * (3 - a)) : w >> (8 * a);
        return {{24{v[7]}}, v[7:0]};
    endfunction

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk_i) begin
            sw_wr_i <= 1'b1;
            sw_addr_i <= a;
            sw_wdata_i <= d;
        end
        @(posedge ref_clk_i) sw_wr_i <= 1'b0;
    endtask

    task automatic chkreg(string name, logic [3:0] a, logic [31:0] exp);
        @(posedge ref_clk_i) begin
            sw_rd_i <= 1'b1;
            sw_addr_i <= a;
        end
        @(posedge ref_clk_i) sw_rd_i <= 1'b0;
        @(negedge ref_clk_i) chk(name, sw_rdata_o, exp);
    endtask

    task automatic endian(logic b);
        @(posedge ref_clk_i) big <= b;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic run(logic [31:0] w, output logic skp);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (instr_ready_o !== 1'b1 && n < 50) begin
            @(negedge ref_clk_i) n++;
        end
        @(posedge ref_clk_i) begin
            instr_valid_i <= 1'b1;
            instr_i <= w;
        end
        @(posedge ref_clk_i) instr_valid_i <= 1'b0;
        n = 0;
        @(negedge ref_clk_i);
        while (done_o !== 1'b1 && n < 50) begin
            @(negedge ref_clk_i) n++;
        end
        chk("done", done_o, 1);
        skp = skipped_o;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pre_imm();
        logic [7:0] offs [4] = '{8'h00, 8'h12, 8'h2e, 8'hf2};
        logic [31:0] a, w;
        logic skp;
        for (int k = 0; k < 4; k++) begin
            a = 32'h10 + offs[k];
            w = hsl_mem_model_i.mem[a[5:2]];
            wr(4'h1, 32'h10);
            run(enc(HSL_AL, 5'b11101, 4'h1, 4'h2, 2'b01, offs[k]), skp);
            chk("skip", skp, 0);
            chk("addr", last_addr, a);
            chkreg("dest", 4'h2, pick(w, a[1:0], 1'b0, 1'b0, 1'b1));
            chkreg("base", 4'h1, 32'h10);
        end
    endtask

    task automatic t_lanes();
        logic [31:0] w;
        logic skp;
        for (int b = 0; b < 2; b++) begin
            endian(b[0]);
            for (int a = 0; a < 4; a++) for (int h = 0; h < 2; h++) if (!(h[0] && a[0])) begin
                w = hsl_mem_model_i.mem[15];
                wr(4'h3, 32'h40);
                wr(4'h4, 32'(4 - a));
                run(enc(HSL_AL, 5'b10011, 4'h3, 4'h5, {1'b1, h[0]}, 8'h04), skp);
                chk("addr", last_addr, 32'(32'h3c + a));
                chk("half", half, h[0]);
                chkreg("dest", 4'h5, pick(w, 2'(a), b[0], 1'b1, h[0]));
                chkreg("base", 4'h3, 32'(32'h3c + a));
            end
        end
    endtask

    task automatic t_post_store();
        logic [31:0] base, w, exp;
        logic skp;
        slow <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            endian(b[0]);
            for (int k = 0; k < 2; k++) begin
                base = 32'(32'h20 + 2 * k);
                wr(4'h6, base);
                wr(4'h7, 32'h1234_a5c3);
                w = hsl_mem_model_i.mem[8];
                run(enc(HSL_AL, 5'b00100, 4'h6, 4'h7, 2'b01, 8'h1a), skp);
                exp = (base[1] ^ b[0]) ? {16'ha5c3, w[15:0]} : {w[31:16], 16'ha5c3};
                chk("addr", last_addr, base);
                chk("wdata", last_wdata, {2{16'ha5c3}});
                chk("word", hsl_mem_model_i.mem[8], exp);
                chkreg("base", 4'h6, base - 32'h1a);
            end
        end
        slow <= 1'b0;
        endian(1'b0);
    endtask

    task automatic t_post_load();
        logic [31:0] w;
        logic skp;
        w = hsl_mem_model_i.mem[9];
        wr(4'ha, 32'h24);
        run(enc(HSL_AL, 5'b01101, 4'ha, 4'hb, 2'b01, 8'h08), skp);
        chk("addr", last_addr, 32'h24);
        chkreg("dest", 4'hb, pick(w, 2'h0, 1'b0, 1'b0, 1'b1));
        chkreg("base", 4'ha, 32'h2c);
        w = hsl_mem_model_i.mem[11];
        wr(4'hc, 32'h2c);
        wr(4'hd, 32'h0000_7e81);
        run(enc(HSL_AL, 5'b11100, 4'hc, 4'hd, 2'b01, 8'h02), skp);
        chk("addr", last_addr, 32'h2e);
        chk("wdata", last_wdata, {2{16'h7e81}});
        chk("word", hsl_mem_model_i.mem[11], {16'h7e81, w[15:0]});
        chkreg("base", 4'hc, 32'h2c);
        chk("align", aerrs, 0);
    endtask

    task automatic t_cond();
        logic skp;
        logic [7:0] n0;
        for (int k = 0; k < 16; k++) begin
            wr(4'h8, 32'h30);
            flags_i <= FL[k];
            run(enc(4'(k), 5'b11111, 4'h8, 4'h9, 2'b01, 8'h04), skp);
            chk("skip", skp, !EX[k]);
            chkreg("base", 4'h8, EX[k] ? 32'h34 : 32'h30);
        end
        flags_i <= 4'h0;
        n0 = acks;
        run(enc(HSL_AL, 5'b11110, 4'h8, 4'h9, 2'b11, 8'h04), skp);
        chk("skip", skp, 1);
        chk("acks", acks, n0);
        chkreg("base", 4'h8, 32'h30);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        for (int k = 0; k < 16; k++) hsl_mem_model_i.mem[k] = 32'h8a35_f147 + k * 32'h1357_9bdf;
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        t_pre_imm();
        t_lanes();
        t_post_store();
        t_post_load();
        t_cond();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        wrap_up();
    end
endmodule // tb_halfword_signed_load_store_unit

/* verilog/hsl_cfg.svh */
`ifndef HSL_CFG_SVH
`define HSL_CFG_SVH
// ****************************************
// Instruction field positions
// ****************************************
`define HSL_COND_HI 31
`define HSL_COND_LO 28
`define HSL_OP_HI 27
`define HSL_OP_LO 25
`define HSL_P_BIT 24
`define HSL_U_BIT 23
`define HSL_I_BIT 22
`define HSL_W_BIT 21
`define HSL_L_BIT 20
`define HSL_RN_HI 19
`define HSL_RN_LO 16
`define HSL_RD_HI 15
`define HSL_RD_LO 12
`define HSL_IMMH_HI 11
`define HSL_IMMH_LO 8
`define HSL_MARK_HI 7
`define HSL_S_BIT 6
`define HSL_H_BIT 5
`define HSL_MARK_LO 4
`define HSL_IMML_HI 3
`define HSL_IMML_LO 0
`define HSL_RM_HI 3
`define HSL_RM_LO 0
// ****************************************
// Encodings and flag positions
// ****************************************
`define HSL_OP_XFER 3'h0
`define HSL_FLAG_N 3
`define HSL_FLAG_Z 2
`define HSL_FLAG_C 1
`define HSL_FLAG_V 0
`define HSL_BYTE_W 8
`define HSL_HALF_W 16
`endif

/* verilog/hsl_lane.sv */
`timescale 1ns/1ps
`include "hsl_cfg.svh"
module hsl_lane #(
    parameter int DW = 32
) (
    // Bus side
    input wire logic [DW-1:0] bus_i,
    input wire logic [1:0] addr_i,
    input wire logic big_i,
    // Transfer kind
    input wire logic sgn_i,
    input wire logic half_i,
    // Register value
    output logic [DW-1:0] val_o
);
    localparam int BW = `HSL_BYTE_W;
    localparam int HW = `HSL_HALF_W;
    logic [1:0] lane;
    logic [BW-1:0] byte_v;
    logic [HW-1:0] half_v;

    always_comb begin
        lane = big_i ? ~addr_i : addr_i;
        byte_v = bus_i[lane*BW +: BW];
        half_v = (addr_i[1] ^ big_i) ? bus_i[HW +: HW] : bus_i[0 +: HW];
        if (half_i) begin
            val_o = {{(DW-HW){sgn_i & half_v[HW-1]}}, half_v};
        end else begin
            val_o = {{(DW-BW){sgn_i & byte_v[BW-1]}}, byte_v};
        end
    end
endmodule // hsl_lane

/* verilog/hsl_pkg.sv */
package hsl_pkg;
    // Condition codes in encoding order
    typedef enum logic [3:0] {
        HSL_EQ, HSL_NE, HSL_CS, HSL_CC, HSL_MI, HSL_PL, HSL_VS, HSL_VC,
        HSL_HI, HSL_LS, HSL_GE, HSL_LT, HSL_GT, HSL_LE, HSL_AL, HSL_NV
    } hsl_cond_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPS, ST_DAT, ST_ACC, ST_WAIT, ST_WBB, ST_WLD
    } hsl_state_t;
endpackage

/* verilog/hsl_regfile.sv */
`timescale 1ns/1ps
module hsl_regfile #(
    parameter int DW = 32,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Core read ports
    input wire logic [AW-1:0] ra_addr_i,
    output logic [DW-1:0] ra_data_o,
    input wire logic [AW-1:0] rb_addr_i,
    output logic [DW-1:0] rb_data_o,
    // Software read port
    input wire logic rc_en_i,
    input wire logic [AW-1:0] rc_addr_i,
    output logic [DW-1:0] rc_data_o,
    // Write ports, port a wins on a clash
    input wire logic wa_en_i,
    input wire logic [AW-1:0] wa_addr_i,
    input wire logic [DW-1:0] wa_data_i,
    input wire logic wb_en_i,
    input wire logic [AW-1:0] wb_addr_i,
    input wire logic [DW-1:0] wb_data_i
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            if (wb_en_i && !(wa_en_i && wa_addr_i == wb_addr_i)) begin
                mem_q[wb_addr_i] <= wb_data_i;
            end
            if (wa_en_i) begin
                mem_q[wa_addr_i] <= wa_data_i;
            end
        end
    end

    // Reads return the value held before a same-cycle write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ra_data_o <= '0;
            rb_data_o <= '0;
            rc_data_o <= '0;
        end else if (ce_i) begin
            ra_data_o <= mem_q[ra_addr_i];
            rb_data_o <= mem_q[rb_addr_i];
            rc_data_o <= rc_en_i ? mem_q[rc_addr_i] : '0;
        end
    end
endmodule // hsl_regfile

/* verilog/hsl_unit.sv */
`timescale 1ns/1ps
`include "hsl_cfg.svh"
module hsl_unit
    import hsl_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Register file access
    input wire logic [AW-1:0] sw_addr_i,
    input wire logic [DW-1:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [DW-1:0] sw_rdata_o,
    // Instruction issue
    input wire logic instr_valid_i,
    input wire logic [DW-1:0] instr_i,
    input wire logic [3:0] flags_i,
    output logic instr_ready_o,
    output logic done_o,
    output logic skipped_o,
    output logic align_err_o,
    // Endianness pin
    input wire logic endian_select_input_i,
    // Memory data bus
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_half_o,
    output logic [DW-1:0] mem_addr_o,
    output logic [DW-1:0] mem_wdata_o,
    input wire logic [DW-1:0] mem_rdata_i,
    input wire logic mem_ack_i
);
    localparam int HW = `HSL_HALF_W;

    hsl_state_t st_q, st_d;
    logic [DW-1:0] instr_q;
    logic [DW-1:0] base_q, off_q, mod_q, ld_q;
    logic end_s1_q, end_s2_q;
    logic ready_q, done_q, skip_q, aerr_q;
    logic req_q, we_q, half_q;
    logic [DW-1:0] addr_q, wdata_q;
    logic [DW-1:0] ra_data, rb_data, lane_val, off_v;
    logic [AW-1:0] rb_addr, wa_addr;
    logic [DW-1:0] wa_data;
    logic wa_en, take, exec_ok, pre_b, up_b, wb_b, ld_b, sg_b, hf_b, imm_b;

    // ****************************************
    // Condition check and decode
    // ****************************************
    function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cf, v;
        n = f[`HSL_FLAG_N];
        z = f[`HSL_FLAG_Z];
        cf = f[`HSL_FLAG_C];
        v = f[`HSL_FLAG_V];
        unique case (hsl_cond_t'(c))
            HSL_EQ: cond_pass = z;
            HSL_NE: cond_pass = !z;
            HSL_CS: cond_pass = cf;
            HSL_CC: cond_pass = !cf;
            HSL_MI: cond_pass = n;
            HSL_PL: cond_pass = !n;
            HSL_VS: cond_pass = v;
            HSL_VC: cond_pass = !v;
            HSL_HI: cond_pass = cf && !z;
            HSL_LS: cond_pass = !cf || z;
            HSL_GE: cond_pass = n == v;
            HSL_LT: cond_pass = n != v;
            HSL_GT: cond_pass = !z && (n == v);
            HSL_LE: cond_pass = z || (n != v);
            HSL_AL: cond_pass = 1'b1;
            HSL_NV: cond_pass = 1'b0;
        endcase
    endfunction

    // Only the halfword/signed encodings are executed; signed stores are ignored
    function automatic logic is_xfer(input logic [DW-1:0] w);
        is_xfer = w[`HSL_OP_HI:`HSL_OP_LO] == `HSL_OP_XFER
            && w[`HSL_MARK_HI] && w[`HSL_MARK_LO]
            && (w[`HSL_S_BIT] || w[`HSL_H_BIT])
            && !(w[`HSL_S_BIT] && !w[`HSL_L_BIT]);
    endfunction

    assign take = instr_valid_i && ready_q;
    assign exec_ok = cond_pass(instr_i[`HSL_COND_HI:`HSL_COND_LO], flags_i) && is_xfer(instr_i);

    always_comb begin
        pre_b = instr_q[`HSL_P_BIT];
        up_b = instr_q[`HSL_U_BIT];
        imm_b = instr_q[`HSL_I_BIT];
        wb_b = instr_q[`HSL_W_BIT];
        ld_b = instr_q[`HSL_L_BIT];
        sg_b = instr_q[`HSL_S_BIT];
        hf_b = instr_q[`HSL_H_BIT];
    end

    // ****************************************
    // Endianness synchroniser
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            end_s1_q <= 1'b0;
            end_s2_q <= 1'b0;
        end else if (ce_i) begin
            end_s1_q <= endian_select_input_i;
            end_s2_q <= end_s1_q;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (take && exec_ok) st_d = ST_OPS;
            ST_OPS: st_d = ST_DAT;
            ST_DAT: st_d = ST_ACC;
            ST_ACC: st_d = ST_WAIT;
            ST_WAIT: begin
                if (mem_ack_i) begin
                    if (!pre_b || wb_b) st_d = ST_WBB;
                    else if (ld_b) st_d = ST_WLD;
                    else st_d = ST_IDLE;
                end
            end
            ST_WBB: st_d = ld_b ? ST_WLD : ST_IDLE;
            ST_WLD: st_d = ST_IDLE;
            // Spare state code falls back to idle
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_IDLE;
            ready_q <= 1'b1;
        end else if (ce_i) begin
            st_q <= st_d;
            ready_q <= st_d == ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            instr_q <= '0;
        end else if (ce_i && take) begin
            instr_q <= instr_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end else if (ce_i) begin
            skip_q <= take && !exec_ok;
            done_q <= (take && !exec_ok) || (st_q != ST_IDLE && st_d == ST_IDLE);
        end
    end

    // ****************************************
    // Address arithmetic
    // ****************************************
    always_comb begin
        if (imm_b) begin
            off_v = {{(DW-`HSL_BYTE_W){1'b0}}, instr_q[`HSL_IMMH_HI:`HSL_IMMH_LO],
                     instr_q[`HSL_IMML_HI:`HSL_IMML_LO]};
        end else begin
            off_v = rb_data;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            base_q <= '0;
            off_q <= '0;
            mod_q <= '0;
        end else if (ce_i && st_q == ST_DAT) begin
            base_q <= ra_data;
            off_q <= off_v;
            mod_q <= up_b ? ra_data + off_v : ra_data - off_v;
        end
    end

    // ****************************************
    // Memory request
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            half_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            aerr_q <= 1'b0;
        end else if (ce_i) begin
            aerr_q <= 1'b0;
            if (st_q == ST_ACC) begin
                req_q <= 1'b1;
                we_q <= !ld_b;
                half_q <= hf_b;
                addr_q <= pre_b ? mod_q : base_q;
                wdata_q <= {rb_data[HW-1:0], rb_data[HW-1:0]};
                // Misaligned halfwords still run; the result is undefined
                aerr_q <= hf_b && (pre_b ? mod_q[0] : base_q[0]);
            end else if (st_q == ST_WAIT && mem_ack_i) begin
                req_q <= 1'b0;
                we_q <= 1'b0;
            end
        end
    end

    // Lane picking and extension
    hsl_lane #(.DW(DW)) u_lane (
        .bus_i(mem_rdata_i),
        .addr_i(addr_q[1:0]),
        .big_i(end_s2_q),
        .sgn_i(sg_b),
        .half_i(hf_b),
        .val_o(lane_val)
    );

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ld_q <= '0;
        end else if (ce_i && st_q == ST_WAIT && mem_ack_i) begin
            ld_q <= lane_val;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always_comb begin
        rb_addr = (st_q == ST_OPS) ? instr_q[`HSL_RM_HI:`HSL_RM_LO] : instr_q[`HSL_RD_HI:`HSL_RD_LO];
        wa_en = st_q == ST_WBB || st_q == ST_WLD;
        // Base goes first so a load into the base register wins
        wa_addr = (st_q == ST_WBB) ? instr_q[`HSL_RN_HI:`HSL_RN_LO] : instr_q[`HSL_RD_HI:`HSL_RD_LO];
        wa_data = (st_q == ST_WBB) ? mod_q : ld_q;
    end

    hsl_regfile #(.DW(DW), .AW(AW)) u_rf (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .ra_addr_i(instr_q[`HSL_RN_HI:`HSL_RN_LO]),
        .ra_data_o(ra_data),
        .rb_addr_i(rb_addr),
        .rb_data_o(rb_data),
        .rc_en_i(sw_rd_i),
        .rc_addr_i(sw_addr_i),
        .rc_data_o(sw_rdata_o),
        .wa_en_i(wa_en),
        .wa_addr_i(wa_addr),
        .wa_data_i(wa_data),
        .wb_en_i(sw_wr_i),
        .wb_addr_i(sw_addr_i),
        .wb_data_i(sw_wdata_i)
    );

    assign instr_ready_o = ready_q;
    assign done_o = done_q;
    assign skipped_o = skip_q;
    assign align_err_o = aerr_q;
    assign mem_req_o = req_q;
    assign mem_we_o = we_q;
    assign mem_half_o = half_q;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = wdata_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_fail_take;
        ce_i && take && !exec_ok;
    endsequence
    sequence s_issue;
        ce_i && st_q == ST_ACC ##1 mem_req_o;
    endsequence

    cond_skip_a: assert property (
        s_fail_take |=> skipped_o && done_o && st_q == ST_IDLE && !mem_req_o)
        else $error("failed condition still started a transfer");
    addr_form_a: assert property (
        s_issue |-> mem_addr_o == (pre_b ? mod_q : base_q))
        else $error("transfer address wrong");
    imm_off_a: assert property (
        ce_i && st_q == ST_DAT && imm_b |=> off_q == {24'h0, instr_q[11:8], instr_q[3:0]})
        else $error("immediate offset wrong");
    reg_off_a: assert property (
        ce_i && st_q == ST_DAT && !imm_b |=> off_q == $past(rb_data))
        else $error("register offset wrong");
    up_down_a: assert property (
        ce_i && st_q == ST_ACC |-> mod_q == (up_b ? base_q + off_q : base_q - off_q))
        else $error("offset direction wrong");
    wb_pick_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && pre_b && !wb_b |=> st_q != ST_WBB)
        else $error("pre-index without write-back changed the base");
    post_wb_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && !pre_b |=> st_q == ST_WBB ##1 1'b1)
        else $error("post-index did not write back");
    sext_byte_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && sg_b && !hf_b |=> ld_q[31:8] == {24{ld_q[7]}})
        else $error("signed byte not extended");
    sext_half_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && sg_b && hf_b |=> ld_q[31:16] == {16{ld_q[15]}})
        else $error("signed halfword not extended");
    zero_half_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && !sg_b |=> ld_q[31:16] == 16'h0)
        else $error("unsigned halfword upper bits not clear");
    lane_le_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && hf_b && !end_s2_q
        |=> ld_q[15:0] == (addr_q[1] ? $past(mem_rdata_i[31:16]) : $past(mem_rdata_i[15:0])))
        else $error("little endian halfword lane wrong");
    lane_be_a: assert property (
        ce_i && st_q == ST_WAIT && mem_ack_i && !hf_b && end_s2_q && addr_q[1:0] == 2'h0
        |=> ld_q[7:0] == $past(mem_rdata_i[31:24]))
        else $error("big endian byte lane wrong");
    store_dup_a: assert property (
        mem_req_o && mem_we_o |-> mem_wdata_o[31:16] == mem_wdata_o[15:0])
        else $error("store halves differ");
endmodule // hsl_unit
